// >>> hw/cxp_pkg.sv
package cxp_pkg;
  // link-side counts, in bus clock periods (one period is one bit time)
  localparam int unsigned POR_CLK_PERIODS = 33;
  localparam int unsigned STUCK_BIT_TIMES = 10;
  localparam int unsigned LINK_CNT_W      = 6;
  // system clock
  localparam int unsigned CLK_PERIOD_NS   = 8;
  // standby dwell before normal mode; no figure given, plain default
  localparam int unsigned T_MODE_CHG_NS   = 800;
  localparam int unsigned MODE_CHG_CYC    = (T_MODE_CHG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // recessive idle that ends an arbitration loss (interframe space)
  localparam int unsigned T_IFS_NS        = 800;
  localparam int unsigned IFS_CYC         = (T_IFS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W           = 16;

  typedef enum logic [1:0] {
    CXP_UNDERVOLT,
    CXP_SLEEP,
    CXP_STANDBY,
    CXP_NORMAL
  } cxp_mode_e;
endpackage

// >>> hw/cxp_link.sv
`timescale 1ns/10ps
module cxp_link (
  input  wire logic bus_clk_i,    // bus clock from the master node
  input  wire logic arst_n_i,     // async reset, active low
  input  wire logic ce_i,         // clock enable, clk_i domain level
  input  wire logic por_run_i,    // start-up count request, clk_i domain level
  input  wire logic txd_i,        // raw transmit pin
  output logic      por_done_o,   // 33 periods seen, link domain level
  output logic      stuck_o       // txd low beyond ten bit times, link domain level
);
  import cxp_pkg::*;

  localparam logic [LINK_CNT_W-1:0] POR_N   = LINK_CNT_W'(POR_CLK_PERIODS);
  localparam logic [LINK_CNT_W-1:0] STUCK_N = LINK_CNT_W'(STUCK_BIT_TIMES);

  logic [2:0] s1;
  logic [2:0] s2;
  logic [LINK_CNT_W-1:0] por_cnt;
  logic [LINK_CNT_W-1:0] next_por_cnt;
  logic [LINK_CNT_W-1:0] low_cnt;
  logic [LINK_CNT_W-1:0] next_low_cnt;
  logic next_por_done;
  logic next_stuck;

  // level crossings: ce, start request, txd pin
  always_ff @(posedge bus_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= 3'h1;
      s2 <= 3'h1;
    end else begin
      s1 <= {ce_i, por_run_i, txd_i};
      s2 <= s1;
    end
  end

  always_comb begin
    next_por_cnt  = por_cnt;
    next_low_cnt  = low_cnt;
    next_por_done = por_done_o;
    next_stuck    = stuck_o;
    if (!s2[1]) begin
      next_por_cnt  = '0;
      next_por_done = 1'b0;
    end else if (s2[2] && !por_done_o) begin
      next_por_cnt  = por_cnt + LINK_CNT_W'(1);
      next_por_done = (por_cnt + LINK_CNT_W'(1)) == POR_N;
    end
    if (s2[0]) begin
      next_low_cnt = '0;
      next_stuck   = 1'b0;
    end else if (s2[2] && low_cnt != STUCK_N) begin
      next_low_cnt = low_cnt + LINK_CNT_W'(1);
      next_stuck   = (low_cnt + LINK_CNT_W'(1)) == STUCK_N;
    end
  end

  always_ff @(posedge bus_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      por_cnt    <= '0;
      low_cnt    <= '0;
      por_done_o <= 1'b0;
      stuck_o    <= 1'b0;
    end else begin
      por_cnt    <= next_por_cnt;
      low_cnt    <= next_low_cnt;
      por_done_o <= next_por_done;
      stuck_o    <= next_stuck;
    end
  end

  a_stuck_count: assert property (@(posedge bus_clk_i) disable iff (!arst_n_i)
    $rose(stuck_o) |-> low_cnt == STUCK_N && !$past(s2[0]))
    else $error("stuck flag rose without ten low bit times");
  a_por_count: assert property (@(posedge bus_clk_i) disable iff (!arst_n_i)
    $rose(por_done_o) |-> por_cnt == POR_N)
    else $error("start-up done before 33 clock periods");
endmodule

// >>> hw/cxp_prot.sv
`timescale 1ns/10ps
// Summary of operation
// - low supply report forces the undervoltage state.
// - undervoltage state keeps the bus driver off.
// - supply recovery goes to standby if sleep control high, else sleep.
// - after recovery the power-on sequence runs before normal operation.
// - undervoltage resets role and transmit inputs, sleep input is left as is; clock, receive, bus pins float.
// - after recovery the bus may drive only after 33 clock periods.
// - after recovery transmit data is valid from the first falling edge.
// - on normal entry the driver stays off until transmit is seen high.
// - transmit low beyond ten bit times is no longer forwarded to the bus.
// - bit mismatch flags arbitration loss; driving stops, node only receives.
// - sleep control high means normal mode, low means sleep mode.
module cxp_prot #(
  parameter int unsigned MODE_CHG = cxp_pkg::MODE_CHG_CYC, // standby dwell, clk cycles
  parameter int unsigned INTERFRAME_SPACE      = cxp_pkg::IFS_CYC       // recessive idle ending a loss
) (
  input  wire logic          clk_i,              // 125 MHz system clock
  input  wire logic          arst_n_i,           // async reset, active low
  input  wire logic          ce_i,               // clock enable
  input  wire logic          bus_clk_i,          // bus clock from master node
  input  wire logic          supply_low_i,       // supply monitor: below lower threshold
  input  wire logic          sleep_control_n_i,  // high normal, low sleep
  input  wire logic          role_select_i,      // high slave, low master
  input  wire logic          txd_i,              // transmit data from controller
  input  wire logic          bus_rx_i,           // received bus level
  output logic               bus_o,              // bus driver value (always low)
  output logic               bus_oe_o,           // bus driver enable
  output logic               rxd_o,              // receive data to controller
  output logic               rxd_oe_o,           // receive pin enable
  output logic               clkpin_o,           // clock pin value in sleep (slave)
  output logic               clkpin_oe_o,        // clock pin enable
  output logic               arb_lost_o,         // arbitration lost
  output cxp_pkg::cxp_mode_e mode_o              // current mode
);
  import cxp_pkg::*;

  localparam logic [TMR_W-1:0] MODE_CHG_T = TMR_W'(MODE_CHG);
  localparam logic [TMR_W-1:0] IFS_T      = TMR_W'(INTERFRAME_SPACE);

  logic [4:0] m1;
  logic [4:0] m2;
  logic [1:0] l1;
  logic [1:0] l2;
  logic       sup_low;
  logic       slp_n;
  logic       role;
  logic       txd;
  logic       brx;
  logic       por_done;
  logic       stuck;
  logic       por_done_raw;
  logic       stuck_raw;

  cxp_mode_e        next_mode;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic [TMR_W-1:0] ifs_cnt;
  logic [TMR_W-1:0] next_ifs_cnt;
  logic txd_q;
  logic next_txd_q;
  logic role_q;
  logic next_role_q;
  logic por_run;
  logic next_por_run;
  logic txd_valid;
  logic next_txd_valid;
  logic gate_open;
  logic next_gate_open;
  logic next_arb_lost;
  logic next_bus_oe;
  logic next_rxd;
  logic next_rxd_oe;
  logic next_clkpin;
  logic next_clkpin_oe;
  logic drive_now;
  logic [1:0] oe_hist;
  logic [1:0] next_oe_hist;

  assign sup_low = m2[4];
  assign slp_n   = m2[3];
  assign role    = m2[2];
  assign txd     = m2[1];
  assign brx     = m2[0];
  assign por_done = l2[1];
  assign stuck    = l2[0];

  // pins and link-domain flags each pass two flops
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // reset reads as low supply and an idle line, so no mode step before the pins are seen
      m1 <= 5'h1b;
      m2 <= 5'h1b;
      l1 <= 2'h0;
      l2 <= 2'h0;
    end else if (ce_i) begin
      m1 <= {supply_low_i, sleep_control_n_i, role_select_i, txd_i, bus_rx_i};
      m2 <= m1;
      l1 <= {por_done_raw, stuck_raw};
      l2 <= l1;
    end
  end

  cxp_link u_link (
    .bus_clk_i  (bus_clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .por_run_i  (por_run),
    .txd_i      (txd_i),
    .por_done_o (por_done_raw),
    .stuck_o    (stuck_raw)
  );

  // the driver pulls low only; recessive is the pull-up
  assign drive_now = (mode_o == CXP_NORMAL) && por_done && txd_valid && gate_open
                     && !txd && !stuck && !arb_lost_o;

  always_comb begin
    next_mode      = mode_o;
    next_tmr       = tmr;
    next_txd_q     = txd;
    next_role_q    = role_q;
    next_por_run   = por_run;
    next_txd_valid = txd_valid;
    next_gate_open = gate_open;
    next_arb_lost  = arb_lost_o;
    next_ifs_cnt   = ifs_cnt;
    next_oe_hist   = {oe_hist[0], bus_oe_o};
    case (mode_o)
      CXP_UNDERVOLT: begin
        next_role_q    = 1'b0;
        next_txd_q     = 1'b0;
        next_por_run   = 1'b0;
        next_txd_valid = 1'b0;
        if (!sup_low) begin
          next_mode    = slp_n ? CXP_STANDBY : CXP_SLEEP;
          next_por_run = 1'b1;
          next_tmr     = '0;
        end
      end
      CXP_SLEEP: begin
        next_role_q = role;
        if (slp_n) begin
          next_mode = CXP_STANDBY;
          next_tmr  = '0;
        end
      end
      CXP_STANDBY: begin
        next_tmr = tmr + TMR_W'(1);
        if (!slp_n) begin
          next_mode = CXP_SLEEP;
        end else if (tmr == MODE_CHG_T - TMR_W'(1)) begin
          next_mode      = CXP_NORMAL;
          next_gate_open = 1'b0;
          next_arb_lost  = 1'b0;
        end
      end
      CXP_NORMAL: begin
        if (!slp_n) begin
          next_mode = CXP_SLEEP;
        end
        if (txd) begin
          next_gate_open = 1'b1;
        end
      end
      default: next_mode = CXP_UNDERVOLT;
    endcase
    // first falling edge of txd after recovery validates data
    if (mode_o != CXP_UNDERVOLT && txd_q && !txd) begin
      next_txd_valid = 1'b1;
    end
    // sending recessive but bus reads dominant: another node won; loss wins over idle clear
    // own release needs two sync stages to echo back, so skip two cycles after driving
    if (mode_o == CXP_NORMAL && bus_oe_o == 1'b0 && oe_hist == 2'h0 && txd && !brx && txd_q) begin
      next_arb_lost = 1'b1;
      next_ifs_cnt  = '0;
    end else if (arb_lost_o) begin
      if (txd && brx) begin
        next_ifs_cnt = ifs_cnt + TMR_W'(1);
        if (ifs_cnt == IFS_T - TMR_W'(1)) begin
          next_arb_lost = 1'b0;
        end
      end else begin
        next_ifs_cnt = '0;
      end
    end
    if (sup_low) begin
      next_mode   = CXP_UNDERVOLT;
      next_role_q = 1'b0;
    end
  end

  // outputs follow mode; undervoltage floats all pins
  always_comb begin
    next_bus_oe    = drive_now && !sup_low;
    next_rxd       = 1'b1;
    next_rxd_oe    = 1'b0;
    next_clkpin    = 1'b1;
    next_clkpin_oe = 1'b0;
    if (!sup_low) begin
      if (next_mode == CXP_NORMAL) begin
        next_rxd    = brx;
        next_rxd_oe = 1'b1;
      end else if (next_mode == CXP_SLEEP) begin
        next_rxd_oe = 1'b1;
        if (role_q) begin
          // slave in sleep passes undecoded bus level so wake pulses are seen
          next_clkpin    = brx;
          next_clkpin_oe = 1'b1;
        end
      end
    end
    if (next_mode == CXP_UNDERVOLT) begin
      next_rxd_oe    = 1'b0;
      next_clkpin_oe = 1'b0;
      next_bus_oe    = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_o      <= CXP_UNDERVOLT;
      tmr         <= '0;
      ifs_cnt     <= '0;
      oe_hist     <= '0;
      txd_q       <= 1'b0;
      role_q      <= 1'b0;
      por_run     <= 1'b0;
      txd_valid   <= 1'b0;
      gate_open   <= 1'b0;
      arb_lost_o  <= 1'b0;
      bus_o       <= 1'b0;
      bus_oe_o    <= 1'b0;
      rxd_o       <= 1'b1;
      rxd_oe_o    <= 1'b0;
      clkpin_o    <= 1'b1;
      clkpin_oe_o <= 1'b0;
    end else if (ce_i) begin
      mode_o      <= next_mode;
      tmr         <= next_tmr;
      ifs_cnt     <= next_ifs_cnt;
      oe_hist     <= next_oe_hist;
      txd_q       <= next_txd_q;
      role_q      <= next_role_q;
      por_run     <= next_por_run;
      txd_valid   <= next_txd_valid;
      gate_open   <= next_gate_open;
      arb_lost_o  <= next_arb_lost;
      bus_o       <= 1'b0;
      bus_oe_o    <= next_bus_oe;
      rxd_o       <= next_rxd;
      rxd_oe_o    <= next_rxd_oe;
      clkpin_o    <= next_clkpin;
      clkpin_oe_o <= next_clkpin_oe;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_uv_enter: assert property (ce_i && sup_low |=> mode_o == CXP_UNDERVOLT)
    else $error("low supply did not force undervoltage");
  a_uv_no_drive: assert property (mode_o == CXP_UNDERVOLT |-> !bus_oe_o)
    else $error("bus driven in undervoltage");
  a_uv_exit: assert property (ce_i && mode_o == CXP_UNDERVOLT && !sup_low |=>
    mode_o == ($past(slp_n) ? CXP_STANDBY : CXP_SLEEP))
    else $error("wrong mode after supply recovery");
  a_por_start: assert property ($past(mode_o) == CXP_UNDERVOLT && mode_o != CXP_UNDERVOLT |-> por_run)
    else $error("power-on sequence not started");
  a_uv_float: assert property (mode_o == CXP_UNDERVOLT |-> !rxd_oe_o && !clkpin_oe_o && !role_q)
    else $error("pins driven or role held in undervoltage");
  a_drive_after_por: assert property (bus_oe_o |-> $past(por_done) && $past(txd_valid))
    else $error("bus driven before start-up count or valid txd");
  a_txd_valid_fall: assert property ($rose(txd_valid) |-> $past(txd_q) && !$past(txd))
    else $error("txd valid without falling edge");
  a_gate_high: assert property ($rose(mode_o == CXP_NORMAL) |-> !gate_open ##1 !bus_oe_o)
    else $error("driver enabled before txd seen high");
  a_stuck_cut: assert property (stuck |=> !bus_oe_o)
    else $error("stuck-low txd still forwarded");
  a_arb_stop: assert property (arb_lost_o |=> !bus_oe_o)
    else $error("driving after arbitration loss");

  c_recover: cover property (mode_o == CXP_UNDERVOLT ##1 mode_o == CXP_STANDBY);
  c_drive: cover property (!bus_oe_o ##1 bus_oe_o);
  c_arb: cover property ($rose(arb_lost_o));
  c_stuck: cover property ($rose(stuck));
endmodule

// >>> test/cxp_bus_node.sv
`timescale 1ns/10ps
module cxp_bus_node (
  input  wire logic bus_i,      // device driver value
  input  wire logic bus_oe_i,   // device driver enable
  input  wire logic dom_i,      // other node pulls the line low
  output logic      bus_clk_o,  // bus clock from the master node
  output logic      bus_rx_o    // resolved line level
);
  // the clocking master (primary or stand-in secondary) never pauses, so no clock loss
  // 80 ns, phase offset from clk_i
  initial begin
    bus_clk_o = 1'b1;
    #3;
    forever #40 bus_clk_o = ~bus_clk_o;
  end
  // wired-and with pull-up: a released line reads high
  // the other node only pulls low when the bench commands it
  assign bus_rx_o = ~((bus_oe_i & ~bus_i) | dom_i);
endmodule

// >>> test/cxp_prot_bench.sv
`timescale 1ns/10ps
module cxp_prot_bench;
  import cxp_pkg::*;
  logic      clk_i;
  logic      arst_n_i;
  logic      supply_low_i;
  logic      sleep_n;
  logic      role;
  logic      txd;
  logic      dom;
  logic      bus_clk;
  logic      bus_rx;
  logic      bus_o;
  logic      bus_oe;
  logic      rxd;
  logic      rxd_oe;
  logic      clkpin;
  logic      clkpin_oe;
  logic      arb_lost;
  cxp_mode_e mode;
  int        error_cnt = 0;
  int        checked = 0;

  cxp_prot #(.MODE_CHG(4), .INTERFRAME_SPACE(4)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .bus_clk_i(bus_clk),
    .supply_low_i(supply_low_i), .sleep_control_n_i(sleep_n), .role_select_i(role),
    .txd_i(txd), .bus_rx_i(bus_rx), .bus_o(bus_o), .bus_oe_o(bus_oe), .rxd_o(rxd),
    .rxd_oe_o(rxd_oe), .clkpin_o(clkpin), .clkpin_oe_o(clkpin_oe), .arb_lost_o(arb_lost),
    .mode_o(mode));

  cxp_bus_node node (.bus_i(bus_o), .bus_oe_i(bus_oe), .dom_i(dom), .bus_clk_o(bus_clk), .bus_rx_o(bus_rx));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_mode(input cxp_mode_e m);
    for (int i = 0; i < 20 && mode !== m; i++) tick(1);
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // low supply at start, recovery, start-up count, first toggle
  task automatic t_recover();
    tick(10);
    check(mode, CXP_UNDERVOLT);
    check({bus_oe, rxd_oe}, 2'h0);
    check({clkpin_oe, 1'b0}, 2'h0);
    supply_low_i = 1'b0;
    wait_mode(CXP_STANDBY);
    check(mode, CXP_STANDBY);
    wait_mode(CXP_NORMAL);
    check(mode, CXP_NORMAL);
    check({rxd_oe, clkpin_oe}, 2'h2);
    txd = 1'b0;
    tick(6);
    check({1'b0, bus_oe}, 2'h0);
    txd = 1'b1;
    tick(360);
    txd = 1'b0;
    tick(6);
    check({bus_o, bus_oe}, 2'h1);
    txd = 1'b1;
    tick(6);
    check({1'b0, bus_oe}, 2'h0);
  endtask

  // normal entry with transmit held low, then the stuck-low cutoff
  task automatic t_entry_stuck();
    sleep_n = 1'b0;
    wait_mode(CXP_SLEEP);
    check(mode, CXP_SLEEP);
    txd = 1'b0;
    sleep_n = 1'b1;
    wait_mode(CXP_NORMAL);
    tick(3);
    check({1'b0, bus_oe}, 2'h0);
    txd = 1'b1;
    tick(6);
    txd = 1'b0;
    tick(6);
    check({1'b0, bus_oe}, 2'h1);
    tick(64);
    check({1'b0, bus_oe}, 2'h1);
    tick(70);
    check({1'b0, bus_oe}, 2'h0);
    txd = 1'b1;
    // held past two link clocks so the link sync sees the rise
    tick(40);
    txd = 1'b0;
    tick(6);
    check({1'b0, bus_oe}, 2'h1);
    txd = 1'b1;
    tick(6);
  endtask

  // another node wins a recessive bit
  task automatic t_arb();
    dom = 1'b1;
    tick(6);
    check({arb_lost, rxd}, 2'h2);
    dom = 1'b0;
    txd = 1'b0;
    tick(6);
    check({1'b0, bus_oe}, 2'h0);
    txd = 1'b1;
    tick(14);
    check({1'b0, arb_lost}, 2'h0);
  endtask

  // supply drop mid-run, recovery into sleep, role swaps
  task automatic t_uv_role();
    role = 1'b1;
    supply_low_i = 1'b1;
    tick(6);
    check(mode, CXP_UNDERVOLT);
    check({bus_oe, rxd_oe}, 2'h0);
    check({clkpin_oe, 1'b0}, 2'h0);
    role = 1'b0;
    sleep_n = 1'b0;
    supply_low_i = 1'b0;
    wait_mode(CXP_SLEEP);
    check(mode, CXP_SLEEP);
    check({1'b0, rxd}, 2'h1);
    role = 1'b1;
    tick(6);
    check({clkpin_oe, clkpin}, 2'h3);
    dom = 1'b1;
    tick(6);
    check({clkpin_oe, clkpin}, 2'h2);
    dom = 1'b0;
    tick(6);
    role = 1'b0;
    tick(6);
    check({clkpin_oe, 1'b0}, 2'h0);
  endtask

  initial begin
    #100000;
    error_cnt++;
    finish_test();
  end

  initial begin
    arst_n_i = 1'b0;
    supply_low_i = 1'b1;
    sleep_n = 1'b1;
    role = 1'b0;
    txd = 1'b1;
    dom = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    check(mode, CXP_UNDERVOLT);
    arst_n_i = 1'b1;
    t_recover();
    t_entry_stuck();
    t_arb();
    t_uv_role();
    finish_test();
  end
endmodule
